/* src/fpci_dec_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface fpci_dec_if #(parameter int AW = 24);
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic          a_unl_a;
  logic          a_unl_b;
  logic          a_prot_a;
  logic          a_prot_b;
  logic          odd_word;
  logic [7:0]    cmd;

  modport dec (input addr, input wdata, output a_unl_a, output a_unl_b,
               output a_prot_a, output a_prot_b, output odd_word, output cmd);
  modport seq (output addr, output wdata, input a_unl_a, input a_unl_b,
               input a_prot_a, input a_prot_b, input odd_word, input cmd);
endinterface
`default_nettype wire

/* src/fpci_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module fpci_decode
  import fpci_pkg::*;
(
  fpci_dec_if.dec d
);

  // address bits 14 and up are don't care for coded cycles
  assign d.a_unl_a  = (d.addr[CODED_AW-1:0] == ADDR_UNLOCK_A);
  assign d.a_unl_b  = (d.addr[CODED_AW-1:0] == ADDR_UNLOCK_B);
  assign d.a_prot_a = (d.addr[CODED_AW-1:0] == ADDR_PROT_A);
  assign d.a_prot_b = (d.addr[CODED_AW-1:0] == ADDR_PROT_B);
  // odd word address is 4n-2
  assign d.odd_word = (d.addr[1:0] == ODD_WORD_LSB);
  assign d.cmd      = d.wdata[7:0];

endmodule // fpci_decode
`default_nettype wire

/* src/fpci_pkg.sv */
package fpci_pkg;

  // ----------------------------------------------------------------
  // coded addresses, compared on bits 13:0 only
  // ----------------------------------------------------------------
  localparam int          CODED_AW      = 14;
  localparam logic [13:0] ADDR_UNLOCK_A = 14'h1554;
  localparam logic [13:0] ADDR_UNLOCK_B = 14'h2AA8;
  localparam logic [13:0] ADDR_PROT_A   = 14'h2A54;
  localparam logic [13:0] ADDR_PROT_B   = 14'h15A8;
  localparam logic [1:0]  ODD_WORD_LSB  = 2'h2;

  // ----------------------------------------------------------------
  // command codes, low data byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK_1   = 8'hA8;
  localparam logic [7:0] CMD_UNLOCK_2   = 8'h54;
  localparam logic [7:0] CMD_READ_RESET = 8'hF0;
  localparam logic [7:0] CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0] CMD_ERASE_EN   = 8'h80;
  localparam logic [7:0] CMD_BLK_ERASE  = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_RESUME     = 8'h30;
  localparam logic [7:0] CMD_SET_PROT   = 8'hC0;
  localparam logic [7:0] CMD_READ_PROT  = 8'h90;
  localparam logic [7:0] CMD_BLK_UNPROT = 8'hC1;

  // ----------------------------------------------------------------
  // full-word codes and protection layout
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_CODE_PROT  = 16'h7FFF;
  localparam logic [15:0] DATA_CODE_UNPRT = 16'hFFFF;
  localparam logic [15:0] DATA_CODE_REPRT = 16'hFFFB;
  localparam logic [15:0] TRAP_OPCODE     = 16'h009B;
  localparam logic [15:0] PR_RESET        = 16'hFFFF;
  localparam int          PR_CODE_BIT     = 15;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_UNL1    = 4'h1,
    ST_UNL2    = 4'h2,
    ST_PGM     = 4'h3,
    ST_ER1     = 4'h4,
    ST_ER2     = 4'h5,
    ST_ER3     = 4'h6,
    ST_BE_MORE = 4'h7,
    ST_PUNL1   = 4'h8,
    ST_PUNL2   = 4'h9,
    ST_SETPR   = 4'hA,
    ST_RDPR    = 4'hB,
    ST_BTU     = 4'hC
  } fpci_state_t;

endpackage

/* src/fpci_top.sv */
`timescale 1ns/100ps
`default_nettype none
module fpci_top
  import fpci_pkg::*;
#(
  parameter int AW = 24
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // cpu access
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  input  wire logic          from_flash,
  output logic [15:0]        rdata_q,
  // flash array and controller
  input  wire logic [15:0]   array_rdata,
  input  wire logic [15:0]   pr_nv,
  input  wire logic          erase_busy,
  output logic               pgm_start_q,
  output logic [AW-1:0]      pgm_addr_q,
  output logic [15:0]        pgm_data_q,
  output logic               blk_erase_q,
  output logic               chip_erase_q,
  output logic               suspend_q,
  output logic               resume_q,
  output logic               abort_q,
  output logic               pr_write_q,
  output logic [15:0]        pr_wdata_q,
  output logic               wr_error_q,
  // protection and suspend state
  output logic               block_unprot_q,
  output logic               code_unprot_q,
  output logic               code_locked_q,
  output logic               suspended_q
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  fpci_dec_if #(.AW(AW)) dec ();
  assign dec.addr  = addr;
  assign dec.wdata = wdata;
  fpci_decode u_dec (.d(dec));

  fpci_state_t state_q;
  logic [15:0] pr_act_q;
  logic        cmd_wr;
  logic        is_rr;

  // flash-fetched writes are code protection toggles, never command cycles
  assign cmd_wr = wr_en && !from_flash;
  assign is_rr  = (dec.cmd == CMD_READ_RESET) && (state_q != ST_PGM);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (cmd_wr) begin
      if (is_rr) begin
        state_q <= ST_IDLE;
      end else begin
        state_q <= ST_IDLE;
        unique case (state_q)
          ST_IDLE: begin
            if (!erase_busy || suspended_q) begin
              if (dec.a_unl_a && dec.cmd == CMD_UNLOCK_1) state_q <= ST_UNL1;
              if (dec.a_prot_a && dec.cmd == CMD_UNLOCK_1) state_q <= ST_PUNL1;
            end
          end
          ST_UNL1:
            if (dec.a_unl_b && dec.cmd == CMD_UNLOCK_2) state_q <= ST_UNL2;
          ST_UNL2: begin
            if (dec.a_unl_a && dec.cmd == CMD_PROGRAM) state_q <= ST_PGM;
            if (dec.a_unl_a && dec.cmd == CMD_ERASE_EN && !suspended_q) state_q <= ST_ER1;
          end
          ST_PGM: state_q <= ST_IDLE;
          ST_ER1:
            if (dec.a_unl_a && dec.cmd == CMD_UNLOCK_1) state_q <= ST_ER2;
          ST_ER2:
            if (dec.a_unl_b && dec.cmd == CMD_UNLOCK_2) state_q <= ST_ER3;
          ST_ER3, ST_BE_MORE:
            if (dec.cmd == CMD_BLK_ERASE) state_q <= ST_BE_MORE;
          ST_PUNL1:
            if (dec.a_prot_b && dec.cmd == CMD_UNLOCK_2) state_q <= ST_PUNL2;
          ST_PUNL2: begin
            if (dec.a_prot_a && dec.cmd == CMD_SET_PROT) state_q <= ST_SETPR;
            if (dec.a_prot_a && dec.cmd == CMD_READ_PROT) state_q <= ST_RDPR;
            if (dec.a_prot_a && dec.cmd == CMD_BLK_UNPROT) state_q <= ST_BTU;
          end
          ST_SETPR, ST_RDPR, ST_BTU: state_q <= ST_IDLE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // erase and program strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pgm_start_q  <= 1'b0;
      pgm_addr_q   <= '0;
      pgm_data_q   <= 16'h0000;
      blk_erase_q  <= 1'b0;
      chip_erase_q <= 1'b0;
      suspend_q    <= 1'b0;
      resume_q     <= 1'b0;
      abort_q      <= 1'b0;
    end else begin
      pgm_start_q  <= cmd_wr && state_q == ST_PGM;
      blk_erase_q  <= cmd_wr && !is_rr && dec.cmd == CMD_BLK_ERASE &&
                      (state_q == ST_ER3 || state_q == ST_BE_MORE);
      chip_erase_q <= cmd_wr && !is_rr && state_q == ST_ER3 && dec.a_unl_a &&
                      dec.cmd == CMD_CHIP_ERASE;
      // suspend also ends a block erase time-out, so the sequencer state is not looked at
      suspend_q    <= cmd_wr && erase_busy && !suspended_q &&
                      dec.cmd == CMD_SUSPEND;
      resume_q     <= cmd_wr && state_q == ST_IDLE && suspended_q &&
                      dec.cmd == CMD_RESUME;
      // read/reset during a running or suspended erase kills it for good
      abort_q      <= cmd_wr && is_rr && (erase_busy || suspended_q);
      if (cmd_wr && state_q == ST_PGM) begin
        pgm_addr_q <= addr;
        pgm_data_q <= wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      suspended_q <= 1'b0;
    end else if (cmd_wr && is_rr) begin
      suspended_q <= 1'b0;
    end else if (cmd_wr && erase_busy && dec.cmd == CMD_SUSPEND) begin
      suspended_q <= 1'b1;
    end else if (cmd_wr && state_q == ST_IDLE && suspended_q && dec.cmd == CMD_RESUME) begin
      suspended_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // protection register
  // ----------------------------------------------------------------
  // the active copy only follows the stored word at reset
  always_ff @(posedge clock) begin
    if (rst) begin
      pr_act_q <= pr_nv;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pr_write_q <= 1'b0;
      pr_wdata_q <= PR_RESET;
      wr_error_q <= 1'b0;
    end else begin
      pr_write_q <= 1'b0;
      wr_error_q <= 1'b0;
      if (cmd_wr && state_q == ST_SETPR && dec.odd_word) begin
        if ((wdata & ~pr_act_q) != 16'h0000) begin
          wr_error_q <= 1'b1;
        end else begin
          pr_write_q <= 1'b1;
          pr_wdata_q <= wdata & pr_act_q;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      block_unprot_q <= 1'b0;
    end else if (cmd_wr && is_rr && state_q == ST_BTU) begin
      block_unprot_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_unprot_q <= 1'b0;
    end else if (wr_en && from_flash && wdata == DATA_CODE_UNPRT) begin
      code_unprot_q <= 1'b1;
    end else if (wr_en && from_flash && wdata == DATA_CODE_REPRT) begin
      code_unprot_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      code_locked_q <= 1'b0;
    end else begin
      code_locked_q <= !pr_act_q[PR_CODE_BIT] && !code_unprot_q;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (rd_en) begin
      if (state_q == ST_RDPR && dec.odd_word) begin
        rdata_q <= pr_act_q;
      end else if (!pr_act_q[PR_CODE_BIT] && !code_unprot_q && !from_flash) begin
        rdata_q <= TRAP_OPCODE;
      end else begin
        rdata_q <= array_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  status_read_a: assert property (@(posedge clock) disable iff (rst)
    rd_en && state_q == ST_RDPR && dec.odd_word |=> rdata_q == $past(pr_act_q))
    else $error("status read did not return protection word");

  code_trap_a: assert property (@(posedge clock) disable iff (rst)
    rd_en && !from_flash && state_q != ST_RDPR && !pr_act_q[PR_CODE_BIT] && !code_unprot_q
    |=> rdata_q == TRAP_OPCODE)
    else $error("protected read did not trap");

  pr_frozen_a: assert property (@(posedge clock) disable iff (rst)
    $stable(pr_act_q))
    else $error("active protection changed without reset");

  set_error_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && state_q == ST_SETPR && dec.odd_word && |(wdata & ~pr_act_q)
    |=> wr_error_q && !pr_write_q)
    else $error("raising a cleared bit not flagged");

  pr_no_raise_a: assert property (@(posedge clock) disable iff (rst)
    pr_write_q |-> (pr_wdata_q & ~pr_act_q) == 16'h0000)
    else $error("protection write raises a cleared bit");

  code_unprot_a: assert property (@(posedge clock) disable iff (rst)
    wr_en && from_flash && wdata == DATA_CODE_UNPRT |=> code_unprot_q ##1 !code_locked_q)
    else $error("code unprotect not taken");

  code_reprot_a: assert property (@(posedge clock) disable iff (rst)
    wr_en && from_flash && wdata == DATA_CODE_REPRT |=> !code_unprot_q)
    else $error("code reprotect not taken");

  read_reset_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && is_rr |=> state_q == ST_IDLE)
    else $error("read reset did not return to idle");

  btu_set_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && is_rr && state_q == ST_BTU |=> block_unprot_q)
    else $error("block unprotect not set");

  suspend_a: assert property (@(posedge clock) disable iff (rst)
    suspend_q |-> suspended_q && !$past(suspended_q))
    else $error("suspend strobe without state change");

  resume_a: assert property (@(posedge clock) disable iff (rst)
    resume_q |-> !suspended_q && $past(suspended_q))
    else $error("resume strobe without state change");

  abort_seq_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && !is_rr && state_q == ST_UNL1 && !(dec.a_unl_b && dec.cmd == CMD_UNLOCK_2)
    |=> state_q == ST_IDLE && !pgm_start_q)
    else $error("broken sequence not aborted");

  suspend_take_a: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && erase_busy && !suspended_q && dec.cmd == CMD_SUSPEND |=> suspend_q && suspended_q)
    else $error("suspend during erase not taken");

  block_hold_a: assert property (@(posedge clock) disable iff (rst)
    $past(block_unprot_q) |-> block_unprot_q)
    else $error("block unprotection dropped without reset");

endmodule // fpci_top
`default_nettype wire

/* test/fpci_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fpci_cpu_model
  import fpci_pkg::*;
(
  // clock
  input  wire logic        clock,
  // cpu cycles
  output var  logic        wr_en,
  output var  logic        rd_en,
  output var  logic [23:0] addr,
  output var  logic [15:0] wdata,
  output var  logic        from_flash
);
  initial begin
    wr_en      = 1'h0;
    rd_en      = 1'h0;
    addr       = 24'h0;
    wdata      = 16'h0;
    from_flash = 1'h0;
  end

  // ----------------------------------------------------------------
  // one bus cycle, write when w is high, read otherwise
  // ----------------------------------------------------------------
  // released addr, wdata and from_flash show the inverse and wr_en, rd_en go low, so a stale value never looks live
  task automatic cyc(input logic w, input logic [23:0] a, input logic [15:0] d, input logic ff);
    @(posedge clock);
    wr_en      <= w;
    rd_en      <= ~w;
    addr       <= a;
    wdata      <= d;
    from_flash <= ff;
    @(posedge clock);
    wr_en      <= 1'h0;
    rd_en      <= 1'h0;
    addr       <= ~a;
    wdata      <= ~d;
    from_flash <= ~ff;
  endtask

  task automatic unl();
    cyc(1'h1, {10'h0, ADDR_UNLOCK_A}, {8'h0, CMD_UNLOCK_1}, 1'h0);
    cyc(1'h1, {10'h0, ADDR_UNLOCK_B}, {8'h0, CMD_UNLOCK_2}, 1'h0);
  endtask

  task automatic punl();
    cyc(1'h1, {10'h0, ADDR_PROT_A}, {8'h0, CMD_UNLOCK_1}, 1'h0);
    cyc(1'h1, {10'h0, ADDR_PROT_B}, {8'h0, CMD_UNLOCK_2}, 1'h0);
  endtask
endmodule // fpci_cpu_model
`default_nettype wire

/* test/test_flash_protection_command_interface.sv */
`timescale 1ns/100ps
`default_nettype none
module test_flash_protection_command_interface
  import fpci_pkg::*;
;
  logic        clock, rst, wr_en, rd_en, from_flash, erase_busy;
  logic [23:0] addr, pgm_addr_q, wa;
  logic [15:0] wdata, rdata_q, array_rdata, pgm_data_q, pr_wdata_q, nv_q, wd;
  logic        pgm_start_q, blk_erase_q, chip_erase_q, suspend_q, resume_q, abort_q;
  logic        pr_write_q, wr_error_q, block_unprot_q, code_unprot_q, code_locked_q, suspended_q;
  logic [7:0]  seen;
  int          fails, checks, seed;

  fpci_cpu_model cpu (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
                      .from_flash(from_flash));

  fpci_top #(.AW(24)) DUT (
    .clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .from_flash(from_flash), .rdata_q(rdata_q), .array_rdata(array_rdata), .pr_nv(nv_q),
    .erase_busy(erase_busy), .pgm_start_q(pgm_start_q), .pgm_addr_q(pgm_addr_q),
    .pgm_data_q(pgm_data_q), .blk_erase_q(blk_erase_q), .chip_erase_q(chip_erase_q),
    .suspend_q(suspend_q), .resume_q(resume_q), .abort_q(abort_q), .pr_write_q(pr_write_q),
    .pr_wdata_q(pr_wdata_q), .wr_error_q(wr_error_q), .block_unprot_q(block_unprot_q),
    .code_unprot_q(code_unprot_q), .code_locked_q(code_locked_q), .suspended_q(suspended_q));

  // ----------------------------------------------------------------
  // array and stored protection word stand-ins
  // ----------------------------------------------------------------
  function automatic logic [15:0] arr(input logic [23:0] a);
    return a[15:0] ^ 16'hC3A5;
  endfunction
  assign array_rdata = arr(addr);

  always #10 clock = ~clock;
  always @(posedge clock) begin
    seen <= seen | {pgm_start_q, blk_erase_q, chip_erase_q, suspend_q, resume_q, abort_q,
                    pr_write_q, wr_error_q};
    if (pr_write_q === 1'h1) begin
      nv_q <= pr_wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] rnd();
    return 24'($random(seed));
  endfunction
  function automatic logic [23:0] odd();
    logic [23:0] a;
    a = rnd();
    a[1:0] = ODD_WORD_LSB;
    return a;
  endfunction

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chkv(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'h1;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    #1;
    seen = 8'h0;
  endtask

  // strobes land on the taking edge, locked level one edge later
  task automatic expect_p(input logic [7:0] e);
    repeat (2) @(posedge clock);
    #1;
    chkv("strobes", {16'h0, e}, {16'h0, seen});
    seen = 8'h0;
  endtask
  task automatic rchk(input logic [23:0] a, input logic ff, input logic [15:0] e);
    cpu.cyc(1'h0, a, 16'h0, ff);
    #1;
    chkv("rdata_q", {8'h0, e}, {8'h0, rdata_q});
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic ff);
    cpu.cyc(1'h1, a, d, ff);
  endtask
  task automatic ucmd(input logic [7:0] c);
    cpu.unl();
    wr({10'h0, ADDR_UNLOCK_A}, {8'h0, c}, 1'h0);
  endtask
  task automatic pcmd(input logic [7:0] c);
    cpu.punl();
    wr({10'h0, ADDR_PROT_A}, {8'h0, c}, 1'h0);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    fails++;
    finish_test();
  end

  initial begin
    seed = 32'hb4904bca;
    clock = 1'h0;
    rst = 1'h1;
    erase_busy = 1'h0;
    nv_q = PR_RESET;
    seen = 8'h0;
    fails = 0;
    checks = 0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      wa = rnd();
      wd = 16'(rnd());
      ucmd(CMD_PROGRAM);
      wr(wa, wd, 1'h0);
      expect_p(8'h80);
      chkv("pgm_addr_q", wa, pgm_addr_q);
      chkv("pgm_data_q", {8'h0, wd}, {8'h0, pgm_data_q});
    end
    wr({10'h0, ADDR_UNLOCK_A}, 16'h00A8, 1'h0);
    wr({10'h0, ADDR_UNLOCK_B}, 16'h0055, 1'h0);
    wr({10'h0, ADDR_UNLOCK_A}, {8'h0, CMD_PROGRAM}, 1'h0);
    wr(rnd(), 16'h1234, 1'h0);
    expect_p(8'h00);
    $display("test program done");
    ucmd(CMD_ERASE_EN);
    cpu.unl();
    wr(rnd(), {8'h0, CMD_BLK_ERASE}, 1'h0);
    expect_p(8'h40);
    @(posedge clock);
    erase_busy <= 1'h1;
    wr(rnd(), {8'h0, CMD_SUSPEND}, 1'h0);
    expect_p(8'h10);
    chk1("suspended_q", 1'h1, suspended_q);
    wr(rnd(), {8'h0, CMD_RESUME}, 1'h0);
    expect_p(8'h08);
    chk1("suspended_q", 1'h0, suspended_q);
    wr(rnd(), {8'h0, CMD_READ_RESET}, 1'h0);
    expect_p(8'h04);
    @(posedge clock);
    erase_busy <= 1'h0;
    ucmd(CMD_ERASE_EN);
    cpu.unl();
    wr({10'h0, ADDR_UNLOCK_A}, {8'h0, CMD_CHIP_ERASE}, 1'h0);
    expect_p(8'h20);
    $display("test erase done");
    pcmd(CMD_SET_PROT);
    wr(odd(), DATA_CODE_PROT, 1'h0);
    expect_p(8'h02);
    chkv("pr_wdata_q", {8'h0, DATA_CODE_PROT}, {8'h0, pr_wdata_q});
    pcmd(CMD_READ_PROT);
    rchk(odd(), 1'h0, PR_RESET);
    wa = rnd();
    wa[1:0] = 2'h0;
    rchk(wa, 1'h0, arr(wa));
    wr(rnd(), {8'h0, CMD_READ_RESET}, 1'h0);
    wa = odd();
    rchk(wa, 1'h0, arr(wa));
    chk1("code_locked_q", 1'h0, code_locked_q);
    do_reset();
    pcmd(CMD_READ_PROT);
    rchk(odd(), 1'h0, DATA_CODE_PROT);
    wr(rnd(), {8'h0, CMD_READ_RESET}, 1'h0);
    chk1("code_locked_q", 1'h1, code_locked_q);
    rchk(rnd(), 1'h0, TRAP_OPCODE);
    wa = rnd();
    rchk(wa, 1'h1, arr(wa));
    pcmd(CMD_SET_PROT);
    wr(odd(), 16'hFFFF, 1'h0);
    expect_p(8'h01);
    $display("test protection done");
    wr(rnd(), DATA_CODE_UNPRT, 1'h0);
    expect_p(8'h00);
    chk1("code_unprot_q", 1'h0, code_unprot_q);
    wr(rnd(), DATA_CODE_UNPRT, 1'h1);
    expect_p(8'h00);
    chk1("code_unprot_q", 1'h1, code_unprot_q);
    wa = rnd();
    rchk(wa, 1'h0, arr(wa));
    wr(rnd(), DATA_CODE_REPRT, 1'h1);
    expect_p(8'h00);
    chk1("code_unprot_q", 1'h0, code_unprot_q);
    rchk(rnd(), 1'h0, TRAP_OPCODE);
    wr(rnd(), DATA_CODE_UNPRT, 1'h1);
    do_reset();
    chk1("code_unprot_q", 1'h0, code_unprot_q);
    rchk(rnd(), 1'h0, TRAP_OPCODE);
    pcmd(CMD_BLK_UNPROT);
    wr(rnd(), {8'h0, CMD_READ_RESET}, 1'h0);
    expect_p(8'h00);
    chk1("block_unprot_q", 1'h1, block_unprot_q);
    do_reset();
    chk1("block_unprot_q", 1'h0, block_unprot_q);
    $display("test unprotect done");
    finish_test();
  end
endmodule // test_flash_protection_command_interface
`default_nettype wire
